// ===== mcs_pkg.sv
// Package: word offsets, bit positions and reset values of the motion status input words
//
// Functional notes
// - Bit 00 of word 6 flags axis 2 following error past its warning limit, bit 08 does so for axis 3.
// - Bit 01 of word 6 shows an active forward limit on axis 2, bit 09 on axis 3.
// - Bit 02 of word 6 shows an active reverse limit on axis 2, bit 10 on axis 3.
// - Bit 03 of word 6 is high during an origin search on axis 2, bit 11 on axis 3.
// - Bit 04 of word 6 is high while axis 2 is in feedhold, bit 12 for axis 3.
// - Bit 05 of word 6 flags axis 2 following error past its hard limit, bit 13 does so for axis 3.
// - Bit 06 of word 6 flags axis 2 past its software forward limit, bit 14 for axis 3.
// - Bit 07 of word 6 flags axis 2 past its software reverse limit, bit 15 for axis 3.
// - Bits 00 to 04 of word 7 carry the program error of tasks 1 to 5, one bit each.
// - Bit 05 of word 7 is high while the backup battery voltage is low.
// - Bit 07 of word 7 is set when a transfer between unit and controller fails.
// - Bits 08 to 15 of word 7 mirror the indicator mode that selects what the 8 panel LEDs show.
// - Data the unit program writes for the host lands in words 8 and 9 at the next refresh.
// - All input words are exchanged at every refresh with no request from either side.

package mcs_pkg;

    localparam int unsigned WORD_W = 16;
    localparam int unsigned ADDR_W = 4;

    // Word offsets relative to base word n
    localparam logic [3:0] OFS_AXIS_STATUS = 4'h6;
    localparam logic [3:0] OFS_TASK_STATUS = 4'h7;
    localparam logic [3:0] OFS_XFER_IN_0   = 4'h8;
    localparam logic [3:0] OFS_XFER_IN_1   = 4'h9;

    // Per-axis field positions within one byte of word 6
    localparam int unsigned AX_FE_WARN  = 0;
    localparam int unsigned AX_FWD_LIM  = 1;
    localparam int unsigned AX_REV_LIM  = 2;
    localparam int unsigned AX_ORIGIN   = 3;
    localparam int unsigned AX_FEEDHOLD = 4;
    localparam int unsigned AX_FE_LIM   = 5;
    localparam int unsigned AX_SW_FWD   = 6;
    localparam int unsigned AX_SW_REV   = 7;
    localparam int unsigned AX2_BASE    = 0;
    localparam int unsigned AX3_BASE    = 8;

    // Word 7 field positions
    localparam int unsigned TASK_ERR_LSB = 0;
    localparam int unsigned TASK_CNT     = 5;
    localparam int unsigned LOW_BATT_BIT = 5;
    localparam int unsigned UNUSED_BIT   = 6;
    localparam int unsigned XFER_ERR_BIT = 7;
    localparam int unsigned IND_MODE_LSB = 8;
    localparam int unsigned IND_MODE_W   = 8;

    // Reset values
    localparam logic [15:0] WORD_RST = 16'h0000;

    // Refresh period in ns and derived cycles at 100 MHz
    localparam int unsigned CLK_PERIOD_NS     = 10;
    localparam int unsigned REFRESH_PERIOD_NS = 10000;
    localparam int unsigned REFRESH_CYCLES    = REFRESH_PERIOD_NS / CLK_PERIOD_NS;

    typedef enum logic [1:0] {
        MCS_IDLE,
        MCS_COPY,
        MCS_DONE
    } mcs_refresh_state_t;

endpackage

// ===== mcs_refresh_timer.sv
// Refresh timer: produces the periodic one-cycle refresh strobe
`timescale 1ns/1ps

module mcs_refresh_timer
    import mcs_pkg::*;
#(
    parameter int unsigned PERIOD = REFRESH_CYCLES
) (
    // Clock and reset
    input  wire logic clk,
    input  wire logic rst_n,
    // Strobe
    output logic      tick
);

    logic [15:0] cnt_r;
    logic [15:0] cnt_nxt;
    logic        tick_nxt;

    always_comb begin
        if (cnt_r == 16'(PERIOD - 1)) begin
            cnt_nxt  = 16'h0000;
            tick_nxt = 1'b1;
        end else begin
            cnt_nxt  = cnt_r + 16'h0001;
            tick_nxt = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cnt_r <= 16'h0000;
            tick  <= 1'b0;
        end else begin
            cnt_r <= cnt_nxt;
            tick  <= tick_nxt;
        end
    end

endmodule

// ===== mcs_sync.sv
// Two-flop synchroniser for a bus of pin levels
`timescale 1ns/1ps

module mcs_sync #(
    parameter int unsigned W = 1
) (
    // Clock and reset
    input  wire logic         clk,
    input  wire logic         rst_n,
    // Levels
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);

    logic [W-1:0] meta_r;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            meta_r <= '0;
            q      <= '0;
        end else begin
            meta_r <= d;
            q      <= meta_r;
        end
    end

endmodule

// ===== mcs_status_words.sv
// Status and transfer input words n+6 to n+9 presented to the host controller
`timescale 1ns/1ps

module mcs_status_words
    import mcs_pkg::*;
#(
    parameter int unsigned REFRESH_PERIOD = REFRESH_CYCLES
) (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rst_n,
    // Axis 2 and 3 conditions, one bit per axis field (pins)
    input  wire logic [7:0]  axis2_cond,
    input  wire logic [7:0]  axis3_cond,
    // Unit conditions
    input  wire logic        low_batt,
    input  wire logic [4:0]  task_err,
    input  wire logic        xfer_err,
    input  wire logic [7:0]  indicator_mode,
    // Unit program writes for the host
    input  wire logic        prog_wr,
    input  wire logic        prog_wr_sel,
    input  wire logic [15:0] prog_wr_data,
    // Host side word area
    input  wire logic [3:0]  host_addr,
    output logic      [15:0] host_io_word_area,
    output logic             refresh_done
);

    ////////////////////////////////////////////////////////////////////////////
    // Synchronise pin-level conditions

    logic [7:0] ax2_s;
    logic [7:0] ax3_s;
    logic       batt_s;

    mcs_sync #(.W(8)) u_sync_ax2 (
        .clk   (clk),
        .rst_n (rst_n),
        .d     (axis2_cond),
        .q     (ax2_s)
    );

    mcs_sync #(.W(8)) u_sync_ax3 (
        .clk   (clk),
        .rst_n (rst_n),
        .d     (axis3_cond),
        .q     (ax3_s)
    );

    mcs_sync #(.W(1)) u_sync_batt (
        .clk   (clk),
        .rst_n (rst_n),
        .d     (low_batt),
        .q     (batt_s)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Refresh strobe

    logic tick;

    mcs_refresh_timer #(.PERIOD(REFRESH_PERIOD)) u_timer (
        .clk   (clk),
        .rst_n (rst_n),
        .tick  (tick)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Word assembly

    function automatic logic [7:0] axis_byte(input logic [7:0] c);
        logic [7:0] b;
        b              = 8'h00;
        b[AX_FE_WARN]  = c[AX_FE_WARN];
        b[AX_FWD_LIM]  = c[AX_FWD_LIM];
        b[AX_REV_LIM]  = c[AX_REV_LIM];
        b[AX_ORIGIN]   = c[AX_ORIGIN];
        b[AX_FEEDHOLD] = c[AX_FEEDHOLD];
        b[AX_FE_LIM]   = c[AX_FE_LIM];
        b[AX_SW_FWD]   = c[AX_SW_FWD];
        b[AX_SW_REV]   = c[AX_SW_REV];
        return b;
    endfunction

    logic [15:0] axis_live;
    logic [15:0] task_live;

    always_comb begin
        axis_live                       = WORD_RST;
        axis_live[AX2_BASE +: 8]        = axis_byte(ax2_s);
        axis_live[AX3_BASE +: 8]        = axis_byte(ax3_s);
        task_live                       = WORD_RST;
        task_live[TASK_ERR_LSB +: TASK_CNT] = task_err;
        task_live[LOW_BATT_BIT]         = batt_s;
        task_live[UNUSED_BIT]           = 1'b0;
        task_live[IND_MODE_LSB +: IND_MODE_W] = indicator_mode;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Transfer error catch: a short error between refreshes is not missed

    logic xerr_pend_r;
    logic xerr_pend_nxt;

    always_comb begin
        // Set wins over the clear taken at refresh
        if (xfer_err) begin
            xerr_pend_nxt = 1'b1;
        end else if (tick) begin
            xerr_pend_nxt = 1'b0;
        end else begin
            xerr_pend_nxt = xerr_pend_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Staged program data, copied at the next refresh

    logic [15:0] stage0_r;
    logic [15:0] stage1_r;
    logic [15:0] stage0_nxt;
    logic [15:0] stage1_nxt;

    always_comb begin
        stage0_nxt = stage0_r;
        stage1_nxt = stage1_r;
        if (prog_wr && !prog_wr_sel) begin
            stage0_nxt = prog_wr_data;
        end
        if (prog_wr && prog_wr_sel) begin
            stage1_nxt = prog_wr_data;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Host-visible words, updated only at refresh

    logic [15:0] w6_r;
    logic [15:0] w7_r;
    logic [15:0] w8_r;
    logic [15:0] w9_r;
    logic [15:0] w6_nxt;
    logic [15:0] w7_nxt;
    logic [15:0] w8_nxt;
    logic [15:0] w9_nxt;
    logic        done_nxt;

    always_comb begin
        w6_nxt   = w6_r;
        w7_nxt   = w7_r;
        w8_nxt   = w8_r;
        w9_nxt   = w9_r;
        done_nxt = 1'b0;
        // Copy happens with no request from either side
        if (tick) begin
            w6_nxt   = axis_live;
            w7_nxt   = task_live;
            w7_nxt[XFER_ERR_BIT] = xerr_pend_r | xfer_err;
            w8_nxt   = stage0_nxt;
            w9_nxt   = stage1_nxt;
            done_nxt = 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            xerr_pend_r  <= 1'b0;
            stage0_r     <= WORD_RST;
            stage1_r     <= WORD_RST;
            w6_r         <= WORD_RST;
            w7_r         <= WORD_RST;
            w8_r         <= WORD_RST;
            w9_r         <= WORD_RST;
            refresh_done <= 1'b0;
        end else begin
            xerr_pend_r  <= xerr_pend_nxt;
            stage0_r     <= stage0_nxt;
            stage1_r     <= stage1_nxt;
            w6_r         <= w6_nxt;
            w7_r         <= w7_nxt;
            w8_r         <= w8_nxt;
            w9_r         <= w9_nxt;
            refresh_done <= done_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read-only host access; no write path exists

    logic [15:0] rd_nxt;

    always_comb begin
        case (host_addr)
            OFS_AXIS_STATUS: rd_nxt = w6_r;
            OFS_TASK_STATUS: rd_nxt = w7_r;
            OFS_XFER_IN_0:   rd_nxt = w8_r;
            OFS_XFER_IN_1:   rd_nxt = w9_r;
            default:         rd_nxt = WORD_RST;
        endcase
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            host_io_word_area <= WORD_RST;
        end else begin
            host_io_word_area <= rd_nxt;
        end
    end

endmodule

// ===== mcs_checker.sv
// Checker: timing and content assertions on the status word ports
`timescale 1ns/1ps

module mcs_checker
    import mcs_pkg::*;
#(
    parameter int unsigned REFRESH_PERIOD = REFRESH_CYCLES
) (
    // Clock and reset
    input wire logic        clk,
    input wire logic        rst_n,
    // Conditions
    input wire logic [7:0]  axis2_cond,
    input wire logic [7:0]  axis3_cond,
    input wire logic        low_batt,
    input wire logic [4:0]  task_err,
    input wire logic        xfer_err,
    input wire logic [7:0]  indicator_mode,
    input wire logic        prog_wr,
    // Host side
    input wire logic [3:0]  host_addr,
    input wire logic [15:0] host_io_word_area,
    input wire logic        refresh_done
);
    // Two periods of quiet input, so sync delay and one tick have both passed
    localparam int STABLE_MIN = 2 * REFRESH_PERIOD + 2;
    logic [30:0] cond_r, cond_nxt;
    logic [15:0] stab_r, stab_nxt;
    logic [15:0] gap_r, gap_nxt;
    logic        seen_r, seen_nxt;

    always_comb begin
        cond_nxt = {axis3_cond, axis2_cond, low_batt, task_err, xfer_err, indicator_mode};
        // Wide enough that the stable window also fits the default refresh period
        stab_nxt = (cond_nxt != cond_r) ? 16'h0000 : stab_r + {15'h0000, stab_r != 16'hFFFF};
        gap_nxt  = refresh_done ? 16'h0000 : gap_r + 16'h0001;
        seen_nxt = seen_r | refresh_done;
    end

    always_ff @(posedge clk) begin
        cond_r <= rst_n ? cond_nxt : 31'h0;
        stab_r <= rst_n ? stab_nxt : 16'h0000;
        gap_r  <= rst_n ? gap_nxt : 16'h0000;
        seen_r <= rst_n ? seen_nxt : 1'b0;
    end

    ////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    a_done_single: assert property (refresh_done |=> !refresh_done)
        else $error("refresh strobe wider than one cycle");
    a_refresh_period: assert property (seen_r && refresh_done |-> gap_r == REFRESH_PERIOD - 1)
        else $error("refresh spacing wrong");
    a_refresh_bound: assert property (gap_r <= REFRESH_PERIOD + 3)
        else $error("refresh missing");
    a_unused_zero: assert property ($past(host_addr) == OFS_TASK_STATUS |-> !host_io_word_area[UNUSED_BIT])
        else $error("unused bit set");
    a_unmapped_zero: assert property (!($past(host_addr) inside {[4'h6:4'h9]}) |-> host_io_word_area == 16'h0000)
        else $error("unmapped word not zero");
    a_words_hold: assert property (
        !$past(refresh_done) && $past(host_addr) == $past(host_addr, 2)
        |-> $stable(host_io_word_area))
        else $error("word changed between refreshes");
    a_axis_word: assert property (
        stab_r >= STABLE_MIN && $past(host_addr) == OFS_AXIS_STATUS
        |-> host_io_word_area == {axis3_cond, axis2_cond})
        else $error("axis word wrong");
    a_unit_word: assert property (
        stab_r >= STABLE_MIN && $past(host_addr) == OFS_TASK_STATUS
        |-> host_io_word_area == {indicator_mode, xfer_err, 1'b0, low_batt, task_err})
        else $error("unit word wrong");

    c_refresh: cover property (refresh_done);
    c_axis_read: cover property (stab_r >= STABLE_MIN && $past(host_addr) == OFS_AXIS_STATUS);
    c_burst_write: cover property (prog_wr ##1 prog_wr ##1 prog_wr);
endmodule

// ===== mcs_host_model.sv
// Host model: reads the status words after every refresh
`timescale 1ns/1ps

module mcs_host_model
    import mcs_pkg::*;
(
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rst_n,
    // Word area
    input  wire logic        refresh_done,
    input  wire logic [15:0] host_io_word_area,
    output logic      [3:0]  host_addr,
    // Read results
    output logic             rd_valid,
    output logic      [3:0]  rd_addr,
    output logic      [15:0] rd_data
);
    // One word below and one above the block probe the unmapped reads
    localparam logic [3:0] RD_LIST [6] = '{4'h5, OFS_AXIS_STATUS, OFS_TASK_STATUS,
                                          OFS_XFER_IN_0, OFS_XFER_IN_1, 4'hA};

    // One process owns every output, so no signal has two drivers
    // Reads start only after a completed refresh and never write
    initial begin
        host_addr = 4'h0;
        rd_valid = 1'b0;
        rd_addr = 4'h0;
        rd_data = 16'h0000;
        forever begin
            @(posedge clk);
            if (rst_n === 1'b1 && refresh_done === 1'b1) begin
                for (int i = 0; i < 6; i++) begin
                    host_addr <= RD_LIST[i];
                    @(posedge clk);
                    #1;
                    rd_valid = 1'b1;
                    rd_addr = RD_LIST[i];
                    rd_data = host_io_word_area;
                end
                @(posedge clk);
                #1;
                rd_valid = 1'b0;
            end
        end
    end
endmodule

// ===== mcs_status_words_bench.sv
// Testbench: random status rounds read back through the host model
`timescale 1ns/1ps

module mcs_status_words_bench;
    import mcs_pkg::*;
    localparam int unsigned PER = 8;
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic [7:0]  axis2_cond = 8'h00;
    logic [7:0]  axis3_cond = 8'h00;
    logic        low_batt = 1'b0;
    logic [4:0]  task_err = 5'h00;
    logic        xfer_err = 1'b0;
    logic [7:0]  indicator_mode = 8'h00;
    logic        prog_wr = 1'b0;
    logic        prog_wr_sel = 1'b0;
    logic [15:0] prog_wr_data = 16'h0000;
    logic [3:0]  host_addr;
    logic [15:0] host_io_word_area;
    logic        refresh_done;
    logic        rd_valid;
    logic [3:0]  rd_addr;
    logic [15:0] rd_data;
    logic [15:0] exp_q[$];
    logic [15:0] w8 = 16'h0000;
    logic [15:0] w9 = 16'h0000;
    logic        px = 1'b0;
    int          seed = 32'h3016e0a8;
    int          mismatches = 0;
    int          samples_checked = 0;

    always #5 clk = ~clk;

    mcs_status_words #(.REFRESH_PERIOD(PER)) dut_u (.clk, .rst_n, .axis2_cond, .axis3_cond, .low_batt,
        .task_err, .xfer_err, .indicator_mode, .prog_wr, .prog_wr_sel, .prog_wr_data, .host_addr,
        .host_io_word_area, .refresh_done);
    mcs_host_model host_u (.clk, .rst_n, .refresh_done, .host_io_word_area, .host_addr, .rd_valid,
        .rd_addr, .rd_data);

    ////////////////////////////////////////////////////////////
    task automatic results();
        $display("checked %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic check_word(input logic [3:0] a, input logic [15:0] got);
        logic [15:0] exp;
        exp = (exp_q.size() > 0) ? exp_q.pop_front() : 16'hXXXX;
        samples_checked++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH word %0h expected %h seen %h", a, exp, got);
        end
    endtask

    // Transfer error is sticky, so the value left over from the last round counts too
    task automatic push_words();
        exp_q.push_back(16'h0000);
        exp_q.push_back({axis3_cond, axis2_cond});
        exp_q.push_back({indicator_mode, xfer_err | px, 1'b0, low_batt, task_err});
        exp_q.push_back(w8);
        exp_q.push_back(w9);
        exp_q.push_back(16'h0000);
    endtask

    task automatic prog_write(input logic sel, input logic [15:0] d);
        prog_wr = 1'b1;
        prog_wr_sel = sel;
        prog_wr_data = d;
        @(negedge clk);
    endtask

    task automatic round(input bit fresh);
        @(posedge clk iff refresh_done === 1'b1);
        @(negedge clk);
        px = xfer_err;
        if (fresh) begin
            {axis2_cond, axis3_cond, indicator_mode} = 24'($random(seed));
            {low_batt, task_err, xfer_err} = 7'($random(seed));
            if (($random(seed) & 1) != 0) begin
                prog_write(1'b0, 16'($random(seed)));
                w8 = 16'($random(seed));
                w9 = 16'($random(seed));
                prog_write(1'b0, w8);
                prog_write(1'b1, w9);
                prog_wr = 1'b0;
            end
        end
        push_words();
    endtask

    always @(posedge clk) begin
        if (rd_valid === 1'b1) begin
            check_word(rd_addr, rd_data);
        end
    end

    initial begin
        repeat (10) @(negedge clk);
        rst_n = 1'b1;
        push_words();
        for (int i = 0; i < 24; i++) round(1'b1);
        $display("random rounds done");
        repeat (3) round(1'b0);
        // Stop between the last check and the reads of the next refresh
        while (exp_q.size() != 0) begin
            @(negedge clk);
        end
        @(negedge clk);
        $display("hold rounds done");
        results();
    end

    initial begin
        repeat (2000) @(posedge clk);
        mismatches++;
        results();
    end
endmodule

bind mcs_status_words mcs_checker #(.REFRESH_PERIOD(REFRESH_PERIOD)) chk_u (.clk, .rst_n, .axis2_cond,
    .axis3_cond, .low_batt, .task_err, .xfer_err, .indicator_mode, .prog_wr, .host_addr, .host_io_word_area,
    .refresh_done);
